// file: verilog/sfr_pkg.sv
// Shared constants, command decode and types for the serial flash read path
package sfr_pkg;

	localparam int         SFR_ADDR_W      = 15;
	localparam logic [7:0] SFR_RST_CONFIRM = 8'hD0;
	localparam logic [7:0] SFR_DUMMY_FILL  = 8'h00;
	localparam int         SFR_HALF_DIV    = 4;
	localparam int         SFR_SAMPLE_LAG  = 2;

	localparam logic [7:0] OPC_READ_FAST = 8'h0B;
	localparam logic [7:0] OPC_READ_SLOW = 8'h03;
	localparam logic [7:0] OPC_READ_DUAL = 8'h3B;
	localparam logic [7:0] OPC_RESET     = 8'hF0;

	typedef enum logic [2:0] {K_BAD, K_READ, K_DUAL, K_ADDR, K_PLAIN, K_RESET} sfr_kind_type;

	typedef struct packed {
		sfr_kind_type kind;
		logic [1:0]   addr_bytes;
		logic [1:0]   dummy_bytes;
		logic         dev_out;
	} sfr_cmd_type;

	function automatic sfr_cmd_type sfr_decode(input logic [7:0] opc);
		sfr_cmd_type c;
		c = '{K_BAD, 2'h0, 2'h0, 1'h0};
		case (opc)
			OPC_READ_FAST: c = '{K_READ, 2'h3, 2'h1, 1'h1};
			OPC_READ_SLOW: c = '{K_READ, 2'h3, 2'h0, 1'h1};
			OPC_READ_DUAL: c = '{K_DUAL, 2'h3, 2'h1, 1'h1};
			8'h81, 8'h20, 8'h52, 8'hD8: c = '{K_ADDR, 2'h3, 2'h0, 1'h0};
			8'h60, 8'hC7, 8'h62: c = '{K_PLAIN, 2'h0, 2'h0, 1'h0};
			8'h02: c = '{K_ADDR, 2'h3, 2'h0, 1'h0};
			8'h06, 8'h04: c = '{K_PLAIN, 2'h0, 2'h0, 1'h0};
			8'h05: c = '{K_PLAIN, 2'h0, 2'h0, 1'h1};
			8'h01, 8'h31: c = '{K_PLAIN, 2'h0, 2'h0, 1'h0};
			8'h9B: c = '{K_ADDR, 2'h3, 2'h0, 1'h0};
			8'h77: c = '{K_ADDR, 2'h3, 2'h2, 1'h1};
			OPC_RESET: c = '{K_RESET, 2'h0, 2'h0, 1'h0};
			8'h9F, 8'h15: c = '{K_PLAIN, 2'h0, 2'h0, 1'h1};
			8'hB9, 8'hAB, 8'h79: c = '{K_PLAIN, 2'h0, 2'h0, 1'h0};
			default: c = '{K_BAD, 2'h0, 2'h0, 1'h0};
		endcase
		return c;
	endfunction

endpackage

// file: verilog/sfr_link_if.sv
// Serial link between the flash end and its host end
`timescale 1ns/100ps
interface sfr_link_if;
	logic cs_n;
	logic sck;
	logic host_si;
	logic host_si_oe;
	logic dev_so;
	logic dev_so_oe;
	logic dev_sio;
	logic dev_sio_oe;
	logic so_w;
	logic si_w;

	// Undriven pins read high, as with a pull-up
	assign si_w = host_si_oe ? host_si : (dev_sio_oe ? dev_sio : 1'h1);
	assign so_w = dev_so_oe ? dev_so : 1'h1;

	modport dev (input cs_n, sck, si_w, output dev_so, dev_so_oe, dev_sio, dev_sio_oe);
	modport host (output cs_n, sck, host_si, host_si_oe, input so_w, si_w);
endinterface

// file: verilog/sfr_dev.sv
// Flash end: command framing, decode and single/dual streaming array reads
`timescale 1ns/100ps
module sfr_dev
	import sfr_pkg::*;
#(
	parameter int ADDR_W = SFR_ADDR_W
) (
	input  logic              clk_sys_i,
	input  logic              arst_n_i,
	sfr_link_if.dev           lnk,
	input  logic              mem_we_i,
	input  logic [ADDR_W-1:0] mem_addr_i,
	input  logic [7:0]        mem_wdata_i,
	output logic              cmd_valid_o,
	output logic              cmd_bad_o,
	output logic [7:0]        cmd_opcode_o,
	output logic [ADDR_W-1:0] cmd_addr_o
);

	typedef enum logic [2:0] {D_OPC, D_ADDR, D_DUMMY, D_DATA, D_CONF, D_IGNORE} sfr_dph_type;

	typedef struct packed {
		sfr_dph_type       ph;
		logic [2:0]        bit_cnt;
		logic [7:0]        sr;
		logic [7:0]        opc;
		logic [1:0]        idx;
		logic [1:0]        dummy_left;
		logic              rd_cmd;
		logic              dual;
		logic [ADDR_W-1:0] addr;
	} sfr_frame_type;

	typedef struct packed {
		logic              tog;
		logic              bad;
		logic [7:0]        opc;
		logic [ADDR_W-1:0] addr;
	} sfr_rep_type;

	typedef struct packed {
		logic so;
		logic so_oe;
		logic second_data_pin;
		logic sio_oe;
	} sfr_pin_type;

	typedef struct packed {
		logic              s1;
		logic              s2;
		logic              s3;
		logic              valid;
		logic              bad;
		logic [7:0]        opc;
		logic [ADDR_W-1:0] addr;
	} sfr_sys_type;

	logic [7:0]    mem [0:(1<<ADDR_W)-1];
	sfr_frame_type fq, fd;
	sfr_rep_type   rq, rd;
	sfr_pin_type   pq, pd;
	sfr_sys_type   sq, sd;
	sfr_cmd_type   dec;
	logic [7:0]    nsr;
	logic [7:0]    rd_byte;
	logic          byte_done;
	logic          frame_rst_n;

	// Deselect clears the frame at once; the link clock may never tick again
	assign frame_rst_n = arst_n_i & ~lnk.cs_n;

	// Array is loaded from the system side and only read from the link side
	always_ff @(posedge clk_sys_i) begin
		if (mem_we_i) begin
			mem[mem_addr_i] <= mem_wdata_i;
		end
	end

	always_comb begin
		fd        = fq;
		rd        = rq;
		nsr       = {fq.sr[6:0], lnk.si_w};
		byte_done = fq.bit_cnt == 3'h7;
		dec       = sfr_decode(nsr);
		fd.sr      = nsr;
		fd.bit_cnt = fq.bit_cnt + 3'h1;
		unique case (fq.ph)
			D_OPC: begin
				if (byte_done) begin
					fd.opc        = nsr;
					fd.dual       = dec.kind == K_DUAL;
					fd.rd_cmd     = dec.kind == K_READ || dec.kind == K_DUAL;
					fd.dummy_left = dec.dummy_bytes;
					fd.idx        = 2'h0;
					if (dec.kind == K_BAD) begin
						rd.tog  = ~rq.tog;
						rd.bad  = 1'h1;
						rd.opc  = nsr;
						fd.ph   = D_IGNORE;
					end else if (dec.addr_bytes != 2'h0) begin
						fd.ph = D_ADDR;
					end else if (dec.kind == K_RESET) begin
						fd.ph = D_CONF;
					end else begin
						rd.tog  = ~rq.tog;
						rd.bad  = 1'h0;
						rd.opc  = nsr;
						fd.ph   = D_IGNORE;
					end
				end
			end
			D_ADDR: begin
				if (byte_done) begin
					// Upper address bits fall off the top of the counter
					fd.addr = {fq.addr[ADDR_W-9:0], nsr};
					fd.idx  = fq.idx + 2'h1;
					if (fq.idx == 2'h2) begin
						rd.tog  = ~rq.tog;
						rd.bad  = 1'h0;
						rd.opc  = fq.opc;
						rd.addr = fd.addr;
						if (!fq.rd_cmd) begin
							fd.ph = D_IGNORE;
						end else if (fq.dummy_left == 2'h0) begin
							fd.ph = D_DATA;
						end else begin
							fd.ph = D_DUMMY;
						end
					end
				end
			end
			D_DUMMY: begin
				if (byte_done) begin
					fd.dummy_left = fq.dummy_left - 2'h1;
					if (fq.dummy_left == 2'h1) begin
						fd.ph = D_DATA;
					end
				end
			end
			D_DATA: begin
				fd.bit_cnt = fq.bit_cnt + (fq.dual ? 3'h2 : 3'h1);
				if (fq.bit_cnt == (fq.dual ? 3'h6 : 3'h7)) begin
					// Natural overflow gives the seamless top-to-zero wrap
					fd.addr = fq.addr + ADDR_W'(1);
				end
			end
			D_CONF: begin
				if (byte_done) begin
					if (nsr == SFR_RST_CONFIRM) begin
						rd.tog = ~rq.tog;
						rd.bad = 1'h0;
						rd.opc = fq.opc;
					end
					fd.ph = D_IGNORE;
				end
			end
			D_IGNORE: begin
				fd.ph = D_IGNORE;
			end
		endcase
	end

	always_ff @(posedge lnk.sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			fq <= '{D_OPC, 3'h0, 8'h00, 8'h00, 2'h0, 2'h0, 1'h0, 1'h0, '0};
		end else begin
			fq <= fd;
		end
	end

	// Report survives deselect, so it is cleared only by the system reset
	always_ff @(posedge lnk.sck or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rq <= '{1'h0, 1'h0, 8'h00, '0};
		end else begin
			rq <= rd;
		end
	end

	always_comb begin
		pd      = '{1'h0, 1'h0, 1'h0, 1'h0};
		rd_byte = mem[fq.addr];
		if (fq.ph == D_DATA) begin
			pd.so_oe  = 1'h1;
			pd.sio_oe = fq.dual;
			pd.so     = fq.dual ? rd_byte[{~fq.bit_cnt[2:1], 1'h1}] : rd_byte[~fq.bit_cnt];
			pd.second_data_pin    = rd_byte[{~fq.bit_cnt[2:1], 1'h0}];
		end
	end

	always_ff @(negedge lnk.sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			pq <= '{1'h0, 1'h0, 1'h0, 1'h0};
		end else begin
			pq <= pd;
		end
	end

	assign lnk.dev_so     = pq.so;
	assign lnk.dev_so_oe  = pq.so_oe;
	assign lnk.dev_sio    = pq.second_data_pin;
	assign lnk.dev_sio_oe = pq.sio_oe;

	// Toggle crossing: report fields are quiet long before the toggle is seen
	always_comb begin
		sd       = sq;
		sd.s1    = rq.tog;
		sd.s2    = sq.s1;
		sd.s3    = sq.s2;
		sd.valid = sq.s2 ^ sq.s3;
		if (sq.s2 ^ sq.s3) begin
			sd.bad  = rq.bad;
			sd.opc  = rq.opc;
			sd.addr = rq.addr;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sq <= '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00, '0};
		end else begin
			sq <= sd;
		end
	end

	assign cmd_valid_o  = sq.valid;
	assign cmd_bad_o    = sq.bad;
	assign cmd_opcode_o = sq.opc;
	assign cmd_addr_o   = sq.addr;

endmodule // sfr_dev

// file: verilog/sfr_host.sv
// Host end: frames commands, makes the serial clock, collects read data
`timescale 1ns/100ps
module sfr_host
	import sfr_pkg::*;
#(
	parameter int HALF_DIV = SFR_HALF_DIV
) (
	input  logic        clk_sys_i,
	input  logic        arst_n_i,
	sfr_link_if.host    lnk,
	input  logic        start_i,
	input  logic [7:0]  opcode_i,
	input  logic [23:0] addr_i,
	input  logic [7:0]  len_i,
	input  logic [7:0]  wr_data_i,
	output logic        busy_o,
	output logic        done_o,
	output logic [7:0]  rx_data_o,
	output logic        rx_valid_o
);

	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_SHIFT, H_END} sfr_hph_type;

	typedef struct packed {
		sfr_hph_type ph;
		logic [7:0]  div;
		logic        sck;
		logic        cs_n;
		logic        si;
		logic        si_oe;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [2:0]  bit_cnt;
		logic [2:0]  pos;
		logic [2:0]  hdr_n;
		logic [1:0]  addr_n;
		logic [7:0]  left;
		logic        in_data;
		logic        dual;
		logic        dev_out;
		logic [23:0] addr;
		logic [1:0]  samp;
		logic        so_s1;
		logic        so_s2;
		logic        sio_s1;
		logic        sio_s2;
		logic        busy;
		logic        done;
		logic        rx_valid;
		logic [7:0]  rx_data;
	} sfr_host_type;

	localparam logic [7:0] DIV_END = 8'(HALF_DIV - 1);

	sfr_host_type hq, hd;
	sfr_cmd_type  dec;
	logic         last;
	logic         wrap;
	logic [7:0]   left_n;

	always_comb begin
		hd          = hq;
		hd.done     = 1'h0;
		hd.rx_valid = 1'h0;
		hd.so_s1    = lnk.so_w;
		hd.so_s2    = hq.so_s1;
		hd.sio_s1   = lnk.si_w;
		hd.sio_s2   = hq.sio_s1;
		hd.samp     = {hq.samp[0], 1'h0};
		dec         = sfr_decode(opcode_i);
		wrap        = hq.div == DIV_END;
		last        = (hq.in_data && hq.dual) ? hq.bit_cnt == 3'h6 : hq.bit_cnt == 3'h7;
		left_n      = hq.in_data ? hq.left - 8'h01 : hq.left;
		// Synced pins are read a fixed lag after the rising edge, before the fall
		if (hq.samp[1] && hq.in_data && hq.dev_out) begin
			hd.rx = hq.dual ? {hq.rx[5:0], hq.so_s2, hq.sio_s2} : {hq.rx[6:0], hq.so_s2};
			if (last) begin
				hd.rx_data  = hd.rx;
				hd.rx_valid = 1'h1;
			end
		end
		if (hq.ph != H_IDLE) begin
			hd.div = wrap ? 8'h00 : hq.div + 8'h01;
		end
		unique case (hq.ph)
			H_IDLE: begin
				if (start_i) begin
					hd.ph      = H_SETUP;
					hd.cs_n    = 1'h0;
					hd.busy    = 1'h1;
					hd.div     = 8'h00;
					hd.tx      = opcode_i;
					hd.si      = opcode_i[7];
					hd.si_oe   = 1'h1;
					hd.bit_cnt = 3'h0;
					hd.pos     = 3'h0;
					hd.addr_n  = dec.addr_bytes;
					hd.hdr_n   = {1'h0, dec.addr_bytes} + {1'h0, dec.dummy_bytes};
					hd.left    = len_i;
					hd.in_data = 1'h0;
					hd.dual    = dec.kind == K_DUAL;
					hd.dev_out = dec.dev_out;
					hd.addr    = addr_i;
				end
			end
			H_SETUP: begin
				if (wrap) begin
					hd.ph = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (wrap && !hq.sck) begin
					hd.sck  = 1'h1;
					hd.samp = {hq.samp[0], 1'h1};
				end else if (wrap) begin
					hd.sck = 1'h0;
					if (!last) begin
						// Dual data moves two bits per clock, so the byte closes at bit six
						hd.bit_cnt = hq.bit_cnt + ((hq.in_data && hq.dual) ? 3'h2 : 3'h1);
						hd.tx      = {hq.tx[6:0], 1'h0};
					end else begin
						hd.bit_cnt = 3'h0;
						if (!hq.in_data && hq.pos != hq.hdr_n) begin
							hd.pos = hq.pos + 3'h1;
							if (hd.pos > {1'h0, hq.addr_n}) begin
								hd.tx = SFR_DUMMY_FILL;
							end else begin
								hd.tx = hq.addr[8'(23 - 8 * (hd.pos - 3'h1)) -: 8];
							end
						end else begin
							hd.left = left_n;
							if (left_n == 8'h00) begin
								hd.ph = H_END;
							end else begin
								hd.in_data = 1'h1;
								hd.tx      = wr_data_i;
								hd.si_oe   = !hq.dev_out;
							end
						end
					end
					hd.si = hd.tx[7];
				end
			end
			H_END: begin
				if (wrap) begin
					hd.ph    = H_IDLE;
					hd.cs_n  = 1'h1;
					hd.si_oe = 1'h0;
					hd.busy  = 1'h0;
					hd.done  = 1'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hq <= '{H_IDLE, 8'h00, 1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 3'h0, 3'h0, 3'h0, 2'h0, 8'h00,
				1'h0, 1'h0, 1'h0, 24'h000000, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00};
		end else begin
			hq <= hd;
		end
	end

	assign lnk.cs_n       = hq.cs_n;
	assign lnk.sck        = hq.sck;
	assign lnk.host_si    = hq.si;
	assign lnk.host_si_oe = hq.si_oe;
	assign busy_o         = hq.busy;
	assign done_o         = hq.done;
	assign rx_data_o      = hq.rx_data;
	assign rx_valid_o     = hq.rx_valid;

endmodule // sfr_host

// file: tb/sfr_link_props.sv
// Link checker: pin ownership, edge discipline and release of the data pins
`timescale 1ns/100ps
module sfr_link_props (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic host_si,
	input wire logic host_si_oe,
	input wire logic dev_so,
	input wire logic dev_so_oe,
	input wire logic dev_sio,
	input wire logic dev_sio_oe
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	property p_desel; cs_n |-> !dev_so_oe && !dev_sio_oe; endproperty
	a_desel: assert property (p_desel) else $error("data pins driven while deselected");
	property p_dual_own; dev_sio_oe |-> dev_so_oe && !host_si_oe; endproperty
	a_dual_own: assert property (p_dual_own) else $error("second data pin ownership wrong");
	property p_dual_start; $rose(dev_sio_oe) |-> $rose(dev_so_oe); endproperty
	a_dual_start: assert property (p_dual_start) else $error("dual pins not enabled together");
	property p_so_fall; dev_so_oe && $past(dev_so_oe) && $changed(dev_so) |-> $fell(sck); endproperty
	a_so_fall: assert property (p_so_fall) else $error("output bit moved off falling clock");
	property p_sio_fall; dev_sio_oe && $past(dev_sio_oe) && $changed(dev_sio) |-> $fell(sck); endproperty
	a_sio_fall: assert property (p_sio_fall) else $error("second pin moved off falling clock");
	property p_oe_fall; $rose(dev_so_oe) |-> $fell(sck) && !cs_n; endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("output enabled off falling clock");
	property p_si_low; host_si_oe && !cs_n && $changed(host_si) |-> !sck; endproperty
	a_si_low: assert property (p_si_low) else $error("input bit moved while clock high");
	property p_idle; cs_n |-> !sck; endproperty
	a_idle: assert property (p_idle) else $error("serial clock high outside frame");
	// Four cycles high matches the host's default divider
	property p_high; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
	a_high: assert property (p_high) else $error("serial clock high phase wrong");

	c_dual: cover property ($rose(dev_sio_oe));
	c_single: cover property ($rose(dev_so_oe) && !dev_sio_oe);
	c_frame: cover property ($fell(cs_n));
endmodule // sfr_link_props

// file: tb/serial_flash_command_read_path_tb_top.sv
// Bench: host and flash ends on one link; reads, decode table, reset mid-frame
`timescale 1ns/100ps
module serial_flash_command_read_path_tb_top;
	import sfr_pkg::*;
	typedef struct packed {
		logic [7:0]  opc;
		logic [23:0] addr;
		logic [7:0]  len;
		logic [14:0] exp_addr;
	} sfr_row_type;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        start = 1'b0;
	logic [7:0]  opcode = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [7:0]  len = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        mem_we = 1'b0;
	logic [14:0] mem_addr = 15'h0000;
	logic [7:0]  mem_wdata = 8'h00;
	logic        busy, done, rx_valid, cmd_valid, cmd_bad, so_seen;
	logic [7:0]  rx_data, cmd_opcode;
	logic [14:0] cmd_addr;
	logic [7:0]  rxq[$];
	int          n_rep, n_errors = 0, tests_run = 0;
	logic [7:0]  ops[20] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h62, 8'h02, 8'h06, 8'h04,
		8'h05, 8'h01, 8'h31, 8'h9B, 8'h77, 8'h9F, 8'h15, 8'hB9, 8'hAB, 8'h79};
	// Upper address bits set on purpose; wrap rows straddle the array top
	sfr_row_type rows[6] = '{'{8'h03, 24'h000010, 8'h03, 15'h0010}, '{8'h0B, 24'hFF8020, 8'h02, 15'h0020},
		'{8'h3B, 24'h000100, 8'h03, 15'h0100}, '{8'h03, 24'h007FFE, 8'h04, 15'h7FFE},
		'{8'h3B, 24'h017FFF, 8'h02, 15'h7FFF}, '{8'h0B, 24'h007FFF, 8'h02, 15'h7FFF}};

	always #12.5 clk_sys = ~clk_sys;

	sfr_link_if sfr_link_if_i ();
	sfr_dev sfr_dev_i (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .lnk(sfr_link_if_i.dev), .mem_we_i(mem_we),
		.mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .cmd_valid_o(cmd_valid), .cmd_bad_o(cmd_bad),
		.cmd_opcode_o(cmd_opcode), .cmd_addr_o(cmd_addr));
	sfr_host sfr_host_i (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .lnk(sfr_link_if_i.host), .start_i(start),
		.opcode_i(opcode), .addr_i(addr), .len_i(len), .wr_data_i(wdata), .busy_o(busy), .done_o(done),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid));
	sfr_link_props sfr_link_props_i (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .cs_n(sfr_link_if_i.cs_n),
		.sck(sfr_link_if_i.sck), .host_si(sfr_link_if_i.host_si), .host_si_oe(sfr_link_if_i.host_si_oe),
		.dev_so(sfr_link_if_i.dev_so), .dev_so_oe(sfr_link_if_i.dev_so_oe), .dev_sio(sfr_link_if_i.dev_sio),
		.dev_sio_oe(sfr_link_if_i.dev_sio_oe));

	always @(posedge clk_sys) begin
		if (rx_valid === 1'b1)
			rxq.push_back(rx_data);
		if (cmd_valid === 1'b1)
			n_rep++;
		if (sfr_link_if_i.dev_so_oe === 1'b1)
			so_seen = 1'b1;
	end

	function automatic logic [7:0] pat(input logic [14:0] a);
		return a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
	endfunction

	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_addr(input string what, input logic [14:0] e, input logic [14:0] g);
		chk_byte({what, " hi"}, {1'b0, e[14:8]}, {1'b0, g[14:8]});
		chk_byte({what, " lo"}, e[7:0], g[7:0]);
	endtask

	task automatic chk_flag(input string what, input logic e, input logic g);
		chk_byte(what, {7'h00, e}, {7'h00, g});
	endtask

	task automatic frame(input logic [7:0] o, input logic [23:0] a, input logic [7:0] n, input logic [7:0] w);
		int t;
		@(negedge clk_sys);
		rxq.delete();
		n_rep = 0;
		so_seen = 1'b0;
		start = 1'b1;
		opcode = o;
		addr = a;
		len = n;
		wdata = w;
		@(negedge clk_sys);
		start = 1'b0;
		chk_flag("busy", 1'b1, busy);
		t = 0;
		while (done !== 1'b1 && t < 20000) begin
			@(negedge clk_sys);
			t++;
		end
		chk_flag("done", 1'b1, done);
		chk_flag("idle", 1'b0, busy);
		@(negedge clk_sys);
	endtask

	// Starts a four-byte read near the array top and pulls reset n cycles later
	task automatic cut(input logic [7:0] o, input int n, input logic e_so);
		@(negedge clk_sys);
		n_rep = 0;
		so_seen = 1'b0;
		start = 1'b1;
		opcode = o;
		addr = 24'h007FFE;
		len = 8'h04;
		@(negedge clk_sys);
		start = 1'b0;
		repeat (n) @(negedge clk_sys);
		chk_flag("streaming", e_so, so_seen);
		arst_n = 1'b0;
		@(negedge clk_sys);
		chk_flag("deselect", 1'b1, sfr_link_if_i.cs_n);
		chk_flag("so off", 1'b0, sfr_link_if_i.dev_so_oe);
		chk_flag("sio off", 1'b0, sfr_link_if_i.dev_sio_oe);
		arst_n = 1'b1;
	endtask

	task automatic check_read(input sfr_row_type r);
		frame(r.opc, r.addr, r.len, 8'h00);
		chk_byte("count", r.len, 8'(rxq.size()));
		for (int k = 0; k < rxq.size(); k++)
			chk_byte("data", pat(r.exp_addr + 15'(k)), rxq[k]);
		chk_flag("report", 1'b1, n_rep == 1);
		chk_byte("opcode", r.opc, cmd_opcode);
		chk_addr("address", r.exp_addr, cmd_addr);
		chk_flag("bad", 1'b0, cmd_bad);
	endtask

	task automatic print_verdict;
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (8) @(negedge clk_sys);
		arst_n = 1'b1;
		for (int i = 0; i < 304; i++) begin
			mem_we = 1'b1;
			mem_addr = (i < 288) ? 15'(i) : 15'(i - 288 + 32'h7FF0);
			mem_wdata = pat(mem_addr);
			@(negedge clk_sys);
		end
		mem_we = 1'b0;
		foreach (rows[i])
			check_read(rows[i]);
		foreach (ops[i]) begin
			frame(ops[i], 24'h001234, 8'h00, 8'h00);
			chk_flag("decoded", 1'b1, n_rep == 1);
			chk_byte("opcode", ops[i], cmd_opcode);
			chk_flag("bad", 1'b0, cmd_bad);
			chk_flag("drove", 1'b0, so_seen);
		end
		frame(8'h9F, 24'h000000, 8'h02, 8'h00);
		chk_byte("released", 8'hFF, rxq[0] & rxq[1]);
		frame(OPC_RESET, 24'h000000, 8'h01, SFR_RST_CONFIRM);
		chk_flag("confirmed", 1'b1, n_rep == 1 && cmd_opcode === OPC_RESET);
		frame(OPC_RESET, 24'h000000, 8'h01, 8'hD1);
		chk_flag("unconfirmed", 1'b0, n_rep != 0);
		frame(8'h5A, 24'h000000, 8'h02, OPC_READ_SLOW);
		chk_flag("bad", 1'b1, cmd_bad);
		chk_flag("ignored", 1'b0, so_seen);
		check_read(rows[3]);
		// Cut mid-address, then mid-byte in a single read and in a dual read
		cut(OPC_READ_SLOW, 147, 1'b0);
		chk_flag("aborted", 1'b0, n_rep != 0);
		cut(OPC_READ_SLOW, 300, 1'b1);
		cut(OPC_READ_DUAL, 364, 1'b1);
		check_read(rows[2]);
		print_verdict();
	end

	initial begin
		#2000000;
		n_errors++;
		print_verdict();
	end
endmodule // serial_flash_command_read_path_tb_top
